// ==== hdl/register_space_regs.vh ====
// register space constants: map ranges, local register offsets, fields
`ifndef REGISTER_SPACE_REGS_VH
`define REGISTER_SPACE_REGS_VH
`define ADDR_W            9
`define DATA_W            16
`define GLB_LO            9'h000
`define GLB_HI            9'h01F
`define PORT_LO           9'h040
`define PORT_HI           9'h05F
`define BERT_LO           9'h060
`define BERT_HI           9'h07F
`define LENC_LO           9'h08C
`define LENC_HI           9'h08F
`define LDEC_LO           9'h090
`define LDEC_HI           9'h09F
`define HDLC_LO           9'h0A0
`define HDLC_HI           9'h0BF
`define FEAC_LO           9'h0C0
`define FEAC_HI           9'h0DF
`define TRAIL_LO          9'h0E8
`define TRAIL_HI          9'h0FF
`define FRM_LO            9'h118
`define FRM_HI            9'h13F
`define TEST_LO           9'h180
`define TEST_HI           9'h19F
// local registers, 16-bit word addresses (bit 0 selects byte in 8-bit mode)
`define REG_CTRL          9'h002
`define REG_CONF          9'h004
`define REG_STAT          9'h014
`define REG_LATCH         9'h016
`define REG_IE            9'h018
`define REG_CNT           9'h01C
`define REG_LIVE          9'h01E
// control register fields
`define CTRL_SNAP         3
`define CTRL_LSEL         2
`define CTRL_MODE         8
`define CTRL_RESET        16'h0000
`define CONF_RESET        16'h0000
// latched bits in use in the current mode; the rest act as reserved
`define LATCH_USED        16'h00FF
// byte lanes in 8-bit bus mode
`define LANE_HI           16'hFF00
`define LANE_LO           16'h00FF
`define ZERO16            16'h0000
`define ONES16            16'hFFFF
`endif

// ==== hdl/register_space_common_logic.v ====
// common register space: decode, latched status, snapshot counters
// Functional notes
// - decode nine-bit address over all banks
// - fixed bank ranges, gaps are unused
// - non-writable banks ignore writes, read zero
// - read-only bits not writable, others read-write
// - unassigned bits discard writes, read zero; control register stores and reads back all sixteen bits
// - datapath ignores config changes during datapath reset
// - counters saturate at maximum
// - snapshot strobe edge starts update, done low
// - copy, clear, zero flag low, then done
// - events during update still counted
// - latched bit needs event gone then back
// - change-latched bit sets on both edges
// - clear-on-read clears sixteen or eight bits
// - clear-on-write clears bits written one
// - reserved config bits store but do nothing
// - reserved status zero, reserved latches never set
// - reserved enables store but never raise interrupt, their latches never set
// - reserved counters hold, snapshot still works
// - datapath reset clears latches and counters
// - ready given only inside function blocks
// - odd byte upper bits, even byte lower
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "register_space_regs.vh"
module register_space_common_logic
#(
	parameter CNT_W = 16
)
(
	input  wire                 ref_clk_i,
	input  wire                 rst_n_i,
	input  wire                 datapath_reset_n_i,
	input  wire                 bus8_mode_i,
	input  wire [`ADDR_W-1:0]   addr_i,
	input  wire [`DATA_W-1:0]   wdata_i,
	input  wire                 wr_i,
	input  wire                 rd_i,
	input  wire [7:0]           event_i,
	input  wire [7:0]           change_sel_i,
	input  wire                 count_event_i,
	output reg  [`DATA_W-1:0]   rdata_o,
	output reg                  ready_o,
	output reg                  irq_o,
	output reg                  snapshot_done_flag_o,
	output reg                  zero_count_o,
	output reg  [`DATA_W-1:0]   conf_o
);

	// true when the address falls inside some function block
	function in_block;
		input [`ADDR_W-1:0] a;
		begin
			in_block = (a <= `GLB_HI) ||
				(a >= `PORT_LO && a <= `BERT_HI) ||
				(a >= `LENC_LO && a <= `LENC_HI) ||
				(a >= `LDEC_LO && a <= `FEAC_HI) ||
				(a >= `TRAIL_LO && a <= `TRAIL_HI) ||
				(a >= `FRM_LO && a <= `FRM_HI) ||
				(a >= `TEST_LO && a <= `TEST_HI);
		end
	endfunction

	// byte-lane mask for an access; odd byte is the upper half
	function [`DATA_W-1:0] lane_mask;
		input         b8;
		input         a0;
		begin
			if (!b8)
				lane_mask = `ONES16;
			else if (a0)
				lane_mask = `LANE_HI;
			else
				lane_mask = `LANE_LO;
		end
	endfunction

	reg  [1:0]          dp_sync;
	reg  [7:0]          ev_meta;
	reg  [7:0]          ev_s;
	reg  [7:0]          ev_d;
	reg                 cnt_meta;
	reg                 cnt_s;
	reg  [7:0]          chg_meta;
	reg  [7:0]          chg_s;
	reg  [`DATA_W-1:0]  ctrl;
	reg  [`DATA_W-1:0]  conf;
	reg  [`DATA_W-1:0]  ie;
	reg  [`DATA_W-1:0]  latch;
	reg  [CNT_W-1:0]    live;
	reg  [CNT_W-1:0]    cnt_reg;
	reg  [1:0]          snap_state;
	reg                 snap_d;
	reg                 mode_d;
	reg                 mode_pend;
	reg  [`DATA_W-1:0]  next_rdata;
	reg  [`DATA_W-1:0]  next_latch;
	reg  [CNT_W-1:0]    next_live;

	localparam S_IDLE = 2'b00;
	localparam S_COPY = 2'b01;
	localparam S_ZERO = 2'b10;

	wire                dp_rst   = ~dp_sync[1];
	wire [`ADDR_W-1:0]  word     = {addr_i[`ADDR_W-1:1], 1'b0};
	wire [`DATA_W-1:0]  mask     = lane_mask(bus8_mode_i, addr_i[0]);
	wire                hit      = in_block(addr_i);
	wire                wr_ok    = wr_i & hit;
	wire                snap_req = ctrl[`CTRL_SNAP] & ~snap_d;
	wire                cnt_sat  = &live;
	wire [`DATA_W-1:0]  wmerge_c = (ctrl & ~mask) | (wdata_i & mask);
	// mode switch: counters of the old mode become reserved
	wire                reserved_cnt = ctrl[`CTRL_MODE];
	// rising edge, plus falling edge where change latching is chosen
	wire [7:0]          ev_set   = (ev_s & ~ev_d) |
		(chg_s & ev_d & ~ev_s);

	// counters of up to 16 bits on the bus: zero-fill above the count
	wire [`DATA_W-1:0]  cnt_rd;
	wire [`DATA_W-1:0]  live_rd;
	genvar              gi;
	generate
		for (gi = 0; gi < `DATA_W; gi = gi + 1)
		begin : g_rd_ext
			if (gi < CNT_W)
			begin : g_bit
				assign cnt_rd[gi]  = cnt_reg[gi];
				assign live_rd[gi] = live[gi];
			end
			else
			begin : g_pad
				assign cnt_rd[gi]  = 1'b0;
				assign live_rd[gi] = 1'b0;
			end
		end
	endgenerate

	// datapath reset pin, two flip-flops
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dp_sync <= 2'b00;
		else
			dp_sync <= {dp_sync[0], datapath_reset_n_i};
	end

	// event, change-select and count pins pass two flip-flops
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ev_meta  <= 8'h00;
			ev_s     <= 8'h00;
			chg_meta <= 8'h00;
			chg_s    <= 8'h00;
			cnt_meta <= 1'b0;
			cnt_s    <= 1'b0;
		end
		else
		begin
			ev_meta  <= event_i;
			ev_s     <= ev_meta;
			chg_meta <= change_sel_i;
			chg_s    <= chg_meta;
			cnt_meta <= count_event_i;
			cnt_s    <= cnt_meta;
		end
	end

	// latched status next value
	always @*
	begin
		next_latch = latch;
		// reserved latches never set by events
		next_latch[7:0] = latch[7:0] | ev_set;
		next_latch = next_latch & `LATCH_USED;
		next_latch = next_latch | (latch & ~`LATCH_USED);
		if (rd_i && hit && word == `REG_LATCH && !ctrl[`CTRL_LSEL])
			next_latch = next_latch & ~(latch & mask);
		if (wr_ok && word == `REG_LATCH && ctrl[`CTRL_LSEL])
			next_latch = next_latch &
				~(latch & wdata_i & mask);
		// a new event in the clear cycle survives
		next_latch = next_latch | ({8'h00, ev_set} & `LATCH_USED);
		if (dp_rst)
			next_latch = `ZERO16;
	end

	// live counter next value
	always @*
	begin
		next_live = live;
		if (snap_state == S_COPY)
			next_live = {CNT_W{1'b0}};
		if (cnt_s && !cnt_sat && !reserved_cnt && !dp_rst)
			next_live = (snap_state == S_COPY) ?
				{{(CNT_W-1){1'b0}}, 1'b1} :
				live + {{(CNT_W-1){1'b0}}, 1'b1};
		if (dp_rst)
			next_live = {CNT_W{1'b0}};
	end

	// read data mux; bank ranges outside the local map read zero
	always @*
	begin
		next_rdata = `ZERO16;
		case (word)
		`REG_CTRL:  next_rdata = ctrl;
		`REG_CONF:  next_rdata = conf;
		`REG_STAT:  next_rdata = {14'h0000, zero_count_o,
				snapshot_done_flag_o};
		`REG_LATCH: next_rdata = latch;
		`REG_IE:    next_rdata = ie;
		`REG_CNT:   next_rdata = cnt_rd;
		`REG_LIVE:  next_rdata = live_rd;
		default:    next_rdata = `ZERO16;
		endcase
		if (bus8_mode_i && addr_i[0])
			next_rdata = {8'h00, next_rdata[15:8]};
		else if (bus8_mode_i)
			next_rdata = {8'h00, next_rdata[7:0]};
	end

	// host port answers, one cycle after the strobe
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= `ZERO16;
			ready_o <= 1'b0;
		end
		else
		begin
			rdata_o <= rd_i ? next_rdata : `ZERO16;
			ready_o <= (rd_i | wr_i) & hit;
		end
	end

	// writable local registers; everything else drops the write
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl <= `CTRL_RESET;
			conf <= `CONF_RESET;
			ie   <= `ZERO16;
		end
		else
		begin
			if (wr_ok && word == `REG_CTRL)
				ctrl <= wmerge_c;
			if (wr_ok && word == `REG_CONF)
				conf <= (conf & ~mask) | (wdata_i & mask);
			if (wr_ok && word == `REG_IE)
				ie <= (ie & ~mask) | (wdata_i & mask);
		end
	end

	// latched status and live counter
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			latch <= `ZERO16;
			live  <= {CNT_W{1'b0}};
			ev_d  <= 8'h00;
		end
		else
		begin
			latch <= next_latch;
			live  <= next_live;
			ev_d  <= ev_s;
		end
	end

	// interrupt, reserved enable bits included
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(latch & ie);
	end

	// datapath holds old config during datapath reset
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			conf_o <= `CONF_RESET;
		else if (!dp_rst)
			conf_o <= conf;
	end

	// edge detector frozen in datapath reset
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			snap_d <= 1'b0;
		else if (!dp_rst)
			snap_d <= ctrl[`CTRL_SNAP];
	end

	// mode tracking
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode_d    <= 1'b0;
			mode_pend <= 1'b0;
		end
		else
		begin
			mode_d <= ctrl[`CTRL_MODE];
			if (ctrl[`CTRL_MODE] != mode_d)
				mode_pend <= 1'b1;
			else if (dp_rst)
				mode_pend <= 1'b0;
		end
	end

	// counter snapshot: copy, clear, zero flag low, then done
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg              <= {CNT_W{1'b0}};
			snap_state           <= S_IDLE;
			snapshot_done_flag_o <= 1'b1;
			zero_count_o         <= 1'b1;
		end
		else if (dp_rst)
		begin
			// datapath reset aborts an update and empties the register
			cnt_reg              <= {CNT_W{1'b0}};
			snap_state           <= S_IDLE;
			snapshot_done_flag_o <= 1'b1;
			zero_count_o         <= (live == {CNT_W{1'b0}});
		end
		else
		begin
			case (snap_state)
			S_IDLE:
			begin
				zero_count_o <= (live == {CNT_W{1'b0}});
				if (snap_req)
				begin
					snapshot_done_flag_o <= 1'b0;
					snap_state           <= S_COPY;
				end
			end
			S_COPY:
			begin
				// held counters of a reserved mode still copy
				cnt_reg      <= live;
				zero_count_o <= 1'b0;
				snap_state   <= S_ZERO;
			end
			S_ZERO:
			begin
				zero_count_o         <= (live == {CNT_W{1'b0}});
				snapshot_done_flag_o <= 1'b1;
				snap_state           <= S_IDLE;
			end
			default:
				snap_state <= S_IDLE;
			endcase
		end
	end

endmodule

// ==== tb/register_space_chk.sv ====
// port-level assertions for the register space block
`timescale 1ns/1ps
`include "register_space_regs.vh"
module register_space_chk
#(
	parameter CNT_W = 16
)
(
	input wire                 ref_clk_i,
	input wire                 rst_n_i,
	input wire                 datapath_reset_n_i,
	input wire                 bus8_mode_i,
	input wire [`ADDR_W-1:0]   addr_i,
	input wire [`DATA_W-1:0]   wdata_i,
	input wire                 wr_i,
	input wire                 rd_i,
	input wire [7:0]           event_i,
	input wire [7:0]           change_sel_i,
	input wire                 count_event_i,
	input wire [`DATA_W-1:0]   rdata_o,
	input wire                 ready_o,
	input wire                 irq_o,
	input wire                 snapshot_done_flag_o,
	input wire                 zero_count_o,
	input wire [`DATA_W-1:0]   conf_o
);
	wire acc = wr_i | rd_i;
	wire [8:0] a = addr_i;
	wire in_blk = a <= `GLB_HI || (a >= `PORT_LO && a <= `BERT_HI)
		|| (a >= `LENC_LO && a <= `FEAC_HI) || (a >= `TRAIL_LO && a <= `TRAIL_HI)
		|| (a >= `FRM_LO && a <= `FRM_HI) || (a >= `TEST_LO && a <= `TEST_HI);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_ready_in: assert property (acc && in_blk |=> ready_o)
		else $error("no ready inside a block");
	chk_ready_out: assert property (acc && !in_blk |=> !ready_o)
		else $error("ready outside any block");
	chk_ready_idle: assert property (!acc |=> !ready_o)
		else $error("ready without access");
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == `ZERO16)
		else $error("read data outside read slot");
	chk_rdata_gap: assert property (rd_i && !in_blk |=> rdata_o == `ZERO16)
		else $error("unused space read nonzero");
	chk_done_start: assert property ($fell(snapshot_done_flag_o) |->
		$past(wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_SNAP], 2))
		else $error("done fell without snapshot");
	chk_done_back: assert property ($fell(snapshot_done_flag_o) |->
		##[1:3] snapshot_done_flag_o)
		else $error("done not restored");
	chk_conf_hold: assert property (!datapath_reset_n_i [*4] |=>
		$stable(conf_o))
		else $error("conf moved in datapath reset");
	chk_zero_dprst: assert property (!datapath_reset_n_i [*5] |->
		zero_count_o)
		else $error("count not cleared by reset");
endmodule
bind register_space_common_logic register_space_chk #(.CNT_W(CNT_W)) chk_inst (.*);

// ==== tb/host_bus.sv ====
// host model driving the register port
`timescale 1ns/1ps
module host_bus
(
	input  wire         ref_clk_i,
	input  wire  [15:0] rdata_i,
	output logic [8:0]  addr_o,
	output logic [15:0] wdata_o,
	output logic        wr_o,
	output logic        rd_o
);
	initial
	begin
		addr_o = 9'h000;
		wdata_o = 16'h0000;
		wr_o = 1'h0;
		rd_o = 1'h0;
	end
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'h1;
		@(posedge ref_clk_i);
		wr_o <= 1'h0;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [8:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		addr_o <= a;
		rd_o <= 1'h1;
		@(posedge ref_clk_i);
		rd_o <= 1'h0;
		#1 d = rdata_i;
	endtask
endmodule

// ==== tb/tb_register_space_common_logic.sv ====
// self-checking bench for the register space block
`timescale 1ns/1ps
`include "register_space_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_register_space_common_logic;
	logic        ref_clk_i, rst_n_i, datapath_reset_n_i, count_event_i;
	logic        bus8_mode_i, wr_i, rd_i, ready_o, irq_o, done, zero;
	logic [7:0]  event_i, change_sel_i;
	logic [8:0]  addr_i;
	logic [15:0] wdata_i, rdata_o, conf_o, ev_n, d, c, l;
	logic [8:0]  gap [6] = '{9'h020, 9'h080, 9'h0E0, 9'h100, 9'h140, 9'h1A0};
	int          n_fail, checked;
	initial
	begin
		ref_clk_i = 1'h0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (count_event_i) ev_n <= ev_n + 16'h0001;
	register_space_common_logic #(.CNT_W(4)) register_space_common_logic_inst (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.datapath_reset_n_i(datapath_reset_n_i), .bus8_mode_i(bus8_mode_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.event_i(event_i), .change_sel_i(change_sel_i),
		.count_event_i(count_event_i), .rdata_o(rdata_o), .ready_o(ready_o),
		.irq_o(irq_o), .snapshot_done_flag_o(done), .zero_count_o(zero),
		.conf_o(conf_o));
	host_bus host_bus_inst (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o),
		.addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task rchk(input logic [8:0] a, input logic [15:0] e);
		host_bus_inst.rd(a, d);
		`CHK(d, e)
	endtask
	// rising edge on the strobe bit, then wait out the update
	task snap;
		host_bus_inst.wr(`REG_CTRL, 16'h0008);
		host_bus_inst.wr(`REG_CTRL, 16'h0000);
		cyc(5);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial
	begin
		{rst_n_i, count_event_i, bus8_mode_i} = 3'h0;
		{event_i, change_sel_i, ev_n} = 32'h0;
		datapath_reset_n_i = 1'h1;
		cyc(3);
		rst_n_i <= 1'h1;
		rchk(`REG_CTRL, `CTRL_RESET);
		rchk(`REG_STAT, 16'h0003);
		host_bus_inst.wr(`REG_CONF, 16'hA5C3);
		rchk(`REG_CONF, 16'hA5C3);
		`CHK(conf_o, 16'hA5C3)
		bus8_mode_i <= 1'h1;
		rchk(9'h005, 16'h00A5);
		rchk(9'h004, 16'h00C3);
		bus8_mode_i <= 1'h0;
		foreach (gap[i])
		begin
			host_bus_inst.wr(gap[i], 16'hFFFF);
			rchk(gap[i], 16'h0000);
		end
		rchk(9'h01A, 16'h0000);
		count_event_i <= 1'h1;
		cyc(1);
		snap;
		count_event_i <= 1'h0;
		cyc(5);
		host_bus_inst.rd(`REG_CNT, c);
		host_bus_inst.rd(`REG_LIVE, l);
		`CHK(c + l, ev_n)
		snap;
		rchk(`REG_CNT, l);
		rchk(`REG_LIVE, 16'h0000);
		snap;
		rchk(`REG_CNT, 16'h0000);
		count_event_i <= 1'h1;
		cyc(20);
		count_event_i <= 1'h0;
		cyc(3);
		snap;
		rchk(`REG_CNT, 16'h000F);
		host_bus_inst.wr(`REG_CTRL, 16'h0100);
		count_event_i <= 1'h1;
		cyc(4);
		count_event_i <= 1'h0;
		cyc(3);
		rchk(`REG_LIVE, 16'h0000);
		host_bus_inst.wr(`REG_CTRL, 16'h0000);
		event_i <= 8'h01;
		cyc(5);
		rchk(`REG_LATCH, 16'h0001);
		rchk(`REG_LATCH, 16'h0000);
		event_i <= 8'h00;
		cyc(5);
		event_i <= 8'h01;
		cyc(5);
		host_bus_inst.wr(`REG_IE, 16'h0001);
		cyc(3);
		`CHK(irq_o, 1'h1)
		rchk(`REG_LATCH, 16'h0001);
		cyc(3);
		`CHK(irq_o, 1'h0)
		change_sel_i <= 8'h02;
		event_i <= 8'h03;
		cyc(5);
		rchk(`REG_LATCH, 16'h0002);
		event_i <= 8'h01;
		cyc(5);
		rchk(`REG_LATCH, 16'h0002);
		host_bus_inst.wr(`REG_CTRL, 16'h0004);
		event_i <= 8'h00;
		cyc(5);
		event_i <= 8'h01;
		cyc(5);
		rchk(`REG_LATCH, 16'h0001);
		rchk(`REG_LATCH, 16'h0001);
		host_bus_inst.wr(`REG_LATCH, 16'hFFFE);
		rchk(`REG_LATCH, 16'h0001);
		host_bus_inst.wr(`REG_LATCH, 16'h0001);
		rchk(`REG_LATCH, 16'h0000);
		event_i <= 8'h00;
		cyc(5);
		event_i <= 8'h01;
		cyc(5);
		datapath_reset_n_i <= 1'h0;
		cyc(5);
		host_bus_inst.wr(`REG_CONF, 16'h1234);
		rchk(`REG_CONF, 16'h1234);
		`CHK(conf_o, 16'hA5C3)
		rchk(`REG_LATCH, 16'h0000);
		rchk(`REG_CNT, 16'h0000);
		datapath_reset_n_i <= 1'h1;
		cyc(5);
		snap;
		rchk(`REG_STAT, 16'h0003);
		rchk(`REG_CNT, 16'h0000);
		stop_test;
	end
endmodule
